//--- bench/lahp_cmd_model.sv
// command interpreter stand-in: busy after each command, then one result byte
`timescale 1ns/1ps
module lahp_cmd_model (
    input  wire logic                 sys_clk,
    input  wire logic                 rstn,
    input  wire logic                 slow,
    input  wire lahp_pkg::lahp_byte_t cmd_out,
    output logic                      cmd_ready,
    output lahp_pkg::lahp_byte_t      result_in
);
    import lahp_pkg::*;
    logic [3:0] busy_q;
    logic [7:0] cmd_q;
    assign cmd_ready = (busy_q == 4'h0);
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            busy_q    <= 4'h0;
            cmd_q     <= 8'h00;
            result_in <= '0;
        end else begin
            // data differs when not valid so a stale byte cannot pass
            result_in <= '{wr: busy_q == 4'h1, data: (busy_q == 4'h1) ? ~cmd_q : cmd_q};
            if (cmd_out.wr) begin
                busy_q <= slow ? 4'hC : 4'h3;
                cmd_q  <= cmd_out.data;
            end else if (busy_q != 4'h0) begin
                busy_q <= busy_q - 4'h1;
            end
        end
    end
endmodule // lahp_cmd_model

//--- bench/lahp_port_chk.sv
// assertions at the legacy audio host port boundary
`timescale 1ns/1ps
module lahp_port_chk (
    input wire logic                  sys_clk,
    input wire logic                  rstn,
    input wire logic [9:0]            compat_port_base,
    input wire logic                  compat_enable,
    input wire lahp_pkg::lahp_io_t    io,
    input wire lahp_pkg::lahp_byte_t  rdata,
    input wire lahp_pkg::lahp_synth_t synth_path,
    input wire logic [7:0]            synth_status,
    input wire lahp_pkg::lahp_byte_t  cmd_out,
    input wire logic                  cmd_ready,
    input wire lahp_pkg::lahp_mixer_t mixer,
    input wire logic                  stereo_output_select,
    input wire logic                  interface_reset,
    input wire logic                  compat_mode
);
    import lahp_pkg::*;
    localparam lahp_mixer_t MIX_DEF = 64'h9901_0000_9999_0101;
    logic       hit;
    logic       wr_hit;
    logic [3:0] ofs;
    logic [7:0] idx_q;
    logic       armed_q;
    assign hit = (io.rd | io.wr) && io.addr_hi == 6'h00 && io.addr[9:4] == compat_port_base[9:4] && compat_enable;
    assign wr_hit = hit && io.wr;
    assign ofs = io.addr[3:0];
    // shadow index and arm bit; stale after a soft reset until the host rewrites the index
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            idx_q   <= 8'h00;
            armed_q <= 1'b0;
        end else if (wr_hit && ofs == 4'h4) begin
            idx_q <= io.wdata;
        end else if (wr_hit && ofs == 4'h6) begin
            armed_q <= io.wdata[0];
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence s_arm_clear;
        wr_hit && ofs == 4'h6 && !io.wdata[0] && armed_q;
    endsequence
    sequence s_defaults;
        mixer == MIX_DEF;
    endsequence
    chk_synth_sel: assert property (
        wr_hit && ofs inside {4'h0, 4'h2, 4'h8} |=> synth_path.sel_wr && !synth_path.data_wr
            && synth_path.port == $past(io.addr[1:0]) && synth_path.wdata == $past(io.wdata))
        else $error("synth select write not forwarded");
    chk_synth_data: assert property (
        wr_hit && ofs inside {4'h1, 4'h3, 4'h9} |=> synth_path.data_wr && !synth_path.sel_wr
            && synth_path.wdata == $past(io.wdata))
        else $error("synth data write not forwarded");
    chk_synth_status: assert property (
        hit && io.rd && ofs inside {4'h0, 4'h2, 4'h8} |=> rdata.wr && rdata.data == $past(synth_status))
        else $error("synth status read wrong");
    chk_no_alias: assert property (
        !hit |=> !rdata.wr && !synth_path.sel_wr && !synth_path.data_wr && !cmd_out.wr)
        else $error("access outside the window answered");
    chk_cmd_fwd: assert property (
        wr_hit && ofs == 4'hC |=> cmd_out.wr && cmd_out.data == $past(io.wdata))
        else $error("command byte not forwarded");
    chk_not_ready: assert property (
        hit && io.rd && ofs == 4'hC && !cmd_ready |=> rdata.wr && !rdata.data[7])
        else $error("ready flag set while interpreter busy");
    chk_mix_main: assert property (
        wr_hit && ofs == 4'h5 && idx_q == 8'h22 |=> mixer.main == $past(io.wdata))
        else $error("main level write lost");
    chk_mix_clear: assert property (
        wr_hit && ofs == 4'h5 && idx_q == 8'h00 |=> s_defaults)
        else $error("mixer defaults not restored");
    chk_soft_reset: assert property (
        s_arm_clear |-> ##2 interface_reset ##1 s_defaults)
        else $error("soft reset sequence ignored");
    chk_stereo_bit: assert property (
        wr_hit && ofs == 4'h5 && idx_q == 8'h0E |=> stereo_output_select == $past(io.wdata[1]))
        else $error("stereo select does not follow format write");
    chk_mode_track: assert property (
        hit |=> compat_mode)
        else $error("compat mode not set by access");
    chk_mode_hold: assert property (
        compat_mode && compat_enable |=> compat_mode)
        else $error("compat mode dropped while enabled");
    chk_mode_clear: assert property (
        !compat_enable |=> !compat_mode)
        else $error("compat mode kept while disabled");
endmodule // lahp_port_chk

//--- bench/lahp_port_tb_top.sv
// self-checking bench for the legacy audio host port
`timescale 1ns/1ps
module lahp_port_tb_top;
    import lahp_pkg::*;
    logic        sys_clk, rstn, compat_enable, cmd_ready, slow, rv_q, result_taken, tk_q;
    logic        stereo_output_select, interface_reset, compat_mode;
    logic [9:0]  compat_port_base;
    logic [7:0]  synth_status, rd_q;
    lahp_io_t    io;
    lahp_byte_t  rdata, cmd_out, result_in, cmd_q;
    lahp_synth_t synth_path, syn_q;
    lahp_mixer_t mixer;
    int          n_errors, compares;

    lahp_port i_dut (.sys_clk, .rstn, .compat_port_base, .compat_enable, .io, .rdata, .synth_path,
        .synth_status, .cmd_out, .cmd_ready, .result_in, .result_taken, .mixer,
        .stereo_output_select, .interface_reset, .compat_mode);
    lahp_cmd_model i_cmd (.sys_clk, .rstn, .slow, .cmd_out, .cmd_ready, .result_in);

    task automatic final_report();
        if (n_errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    endtask

    // one access per call with an idle cycle after, so io is never driven twice in a step
    task automatic acc(input logic r, input logic w, input logic [9:0] a, input logic [7:0] d,
                       input logic [5:0] hi);
        @(negedge sys_clk);
        io = '{rd: r, wr: w, addr: a, addr_hi: hi, wdata: d};
        @(negedge sys_clk);
        io = '0;
        rv_q = rdata.wr;
        rd_q = rdata.data;
        syn_q = synth_path;
        cmd_q = cmd_out;
        tk_q = result_taken;
    endtask

    task automatic wr(input logic [3:0] ofs, input logic [7:0] d);
        acc(1'b0, 1'b1, {compat_port_base[9:4], ofs}, d, 6'h00);
    endtask

    task automatic rd(input logic [3:0] ofs);
        acc(1'b1, 1'b0, {compat_port_base[9:4], ofs}, 8'h00, 6'h00);
    endtask

    task automatic poll(input logic [3:0] ofs);
        int i;
        for (i = 0; i < 40; i++) begin
            rd(ofs);
            if (rd_q[7] === 1'b1) break;
        end
        if (i == 40) begin
            n_errors++;
            final_report();
        end
    endtask

    task automatic t_mixer();
        logic [7:0] idx [8] = '{8'h04, 8'h0A, 8'h0C, 8'h0E, 8'h22, 8'h26, 8'h28, 8'h2E};
        logic [7:0] dfl [8] = '{8'h99, 8'h01, 8'h00, 8'h00, 8'h99, 8'h99, 8'h01, 8'h01};
        logic [7:0] kept [8] = '{8'hFF, 8'h07, 8'h06, 8'h02, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
        logic [7:0] rsv [7] = '{8'h02, 8'h06, 8'h08, 8'h20, 8'h24, 8'h2A, 8'h2C};
        cmp("mixer_reset", 64'h9901_0000_9999_0101, mixer);
        for (int i = 0; i < 8; i++) begin
            wr(4'h4, idx[i]);
            rd(4'h5);
            cmp("mix_default", dfl[i], rd_q);
            wr(4'h5, 8'hFF);
            rd(4'h5);
            cmp("mix_kept", kept[i], rd_q);
        end
        cmp("stereo_on", 1, stereo_output_select);
        wr(4'h4, 8'h0C);
        for (int c = 0; c < 4; c++) begin
            wr(4'h5, {5'h00, c[1:0], 1'b0});
            cmp("source_code", {c[1:0], 1'b0}, mixer.source[2:0]);
        end
        foreach (rsv[i]) begin
            wr(4'h4, rsv[i]);
            wr(4'h5, 8'h5A);
            rd(4'h5);
            cmp("reserved_read", 8'hFF, rd_q);
        end
        cmp("mixer_untouched", 64'hFF07_0602_FFFF_FFFF, mixer);
        wr(4'h4, 8'h00);
        wr(4'h5, 8'h3C);
        cmp("mixer_cleared", 64'h9901_0000_9999_0101, mixer);
        cmp("stereo_off", 0, stereo_output_select);
    endtask

    task automatic t_synth();
        logic [3:0] so [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9};
        foreach (so[i]) begin
            wr(so[i], 8'h10 + 8'(i));
            cmp("synth_fwd", {~so[i][0], so[i][0], so[i][1:0], 8'h10 + 8'(i)}, syn_q);
            synth_status = 8'h30 + 8'(i);
            if (!so[i][0]) rd(so[i]);
            if (!so[i][0]) cmp("synth_status", {1'b1, 8'h30 + 8'(i)}, {rv_q, rd_q});
        end
    endtask

    task automatic t_decode();
        compat_port_base = 10'h227;
        acc(1'b1, 1'b0, 10'h220, 8'h00, 6'h00);
        cmp("low_base_ignored", 1, rv_q);
        acc(1'b1, 1'b0, 10'h230, 8'h00, 6'h00);
        cmp("outside_window", 0, rv_q);
        acc(1'b0, 1'b1, 10'h220, 8'h00, 6'h01);
        cmp("high_bits_write", 0, syn_q.sel_wr);
        acc(1'b1, 1'b0, 10'h220, 8'h00, 6'h20);
        cmp("high_bits_read", 0, rv_q);
        compat_port_base = 10'h220;
        compat_enable = 1'b0;
        rd(4'h0);
        cmp("disabled_read", 0, rv_q);
        cmp("mode_cleared", 0, compat_mode);
        compat_enable = 1'b1;
        rd(4'h0);
        cmp("mode_set", 1, compat_mode);
        rd(4'hF);
        cmp("unmapped_read", 8'hFF, rd_q);
    endtask

    task automatic t_command();
        for (int s = 0; s < 2; s++) begin
            slow = s[0];
            poll(4'hC);
            wr(4'hC, 8'h40 + 8'(s));
            cmp("cmd_fwd", {1'b1, 8'h40 + 8'(s)}, cmd_q);
            rd(4'hC);
            cmp("busy_flag", 0, rd_q[7]);
            poll(4'hE);
            rd(4'hA);
            cmp("result_byte", 8'(~(8'h40 + 8'(s))), rd_q);
            cmp("result_taken", 1, tk_q);
            rd(4'hE);
            cmp("avail_cleared", 0, rd_q[7]);
        end
    endtask

    task automatic t_soft_reset();
        int i;
        wr(4'h4, 8'h22);
        wr(4'h5, 8'h33);
        wr(4'h6, 8'h00);
        wr(4'h6, 8'h01);
        cmp("no_reset_yet", 8'h33, mixer.main);
        wr(4'h6, 8'hFE);
        for (i = 0; i < 8 && interface_reset !== 1'b1; i++) @(negedge sys_clk);
        cmp("reset_pulse", 1, interface_reset);
        repeat (2) @(negedge sys_clk);
        cmp("reset_defaults", 64'h9901_0000_9999_0101, mixer);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    initial begin
        rstn = 1'b0;
        io = '0;
        compat_enable = 1'b1;
        compat_port_base = 10'h220;
        synth_status = 8'h00;
        slow = 1'b0;
        n_errors = 0;
        compares = 0;
        repeat (20) @(negedge sys_clk);
        rstn = 1'b1;
        t_mixer();
        t_synth();
        t_decode();
        t_command();
        t_soft_reset();
        final_report();
    end
endmodule // lahp_port_tb_top

bind lahp_port lahp_port_chk i_chk (.sys_clk, .rstn, .compat_port_base, .compat_enable, .io, .rdata,
    .synth_path, .synth_status, .cmd_out, .cmd_ready, .mixer, .stereo_output_select,
    .interface_reset, .compat_mode);

//--- rtl/lahp_mixer_bank.sv
// compatibility mixer register bank with registered read data
`timescale 1ns/1ps
`include "lahp_params.svh"
module lahp_mixer_bank (
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    input  wire logic              clear,
    input  wire logic              wr,
    input  wire logic [7:0]        index,
    input  wire logic [7:0]        wdata,
    output lahp_pkg::lahp_mixer_t  regs,
    output logic      [7:0]        rdata
);
    import lahp_pkg::*;

    typedef struct packed {
        lahp_mixer_t mix;
        logic [7:0]  rd;
    } lahp_bank_st_t;

    lahp_bank_st_t st_q;
    lahp_bank_st_t st_d;

    function automatic lahp_mixer_t defaults();
        lahp_mixer_t m;
        m.voice  = `LAHP_RST_VOICE;   // [R13]
        m.mic    = `LAHP_RST_MIC;     // [R14]
        m.source = `LAHP_RST_SOURCE;
        m.format = `LAHP_RST_FORMAT;
        m.main   = `LAHP_RST_MAIN;    // [R17]
        m.synth  = `LAHP_RST_SYNTH;   // [R18]
        m.disc   = `LAHP_RST_DISC;    // [R19]
        m.line   = `LAHP_RST_LINE;    // [R20]
        return m;
    endfunction

    always_comb begin
        st_d = st_q;
        case (index)
            `LAHP_MIX_VOICE:  st_d.rd = st_q.mix.voice;
            `LAHP_MIX_MIC:    st_d.rd = st_q.mix.mic;
            `LAHP_MIX_SOURCE: st_d.rd = st_q.mix.source;
            `LAHP_MIX_FORMAT: st_d.rd = st_q.mix.format;
            `LAHP_MIX_MAIN:   st_d.rd = st_q.mix.main;
            `LAHP_MIX_SYNTH:  st_d.rd = st_q.mix.synth;
            `LAHP_MIX_DISC:   st_d.rd = st_q.mix.disc;
            `LAHP_MIX_LINE:   st_d.rd = st_q.mix.line;
            default:          st_d.rd = `LAHP_RESERVED_READ; // [R21]
        endcase
        if (clear) begin
            st_d.mix = defaults();
        end else if (wr) begin
            case (index) // [R6]
                `LAHP_MIX_RESET:  st_d.mix = defaults(); // [R12]
                `LAHP_MIX_VOICE:  st_d.mix.voice = wdata;
                `LAHP_MIX_MIC:    st_d.mix.mic = {5'h00, wdata[`LAHP_MIC_MSB:0]}; // [R14]
                `LAHP_MIX_SOURCE: st_d.mix.source = {5'h00, wdata[`LAHP_SRC_MSB:`LAHP_SRC_LSB], 1'b0}; // [R15]
                `LAHP_MIX_FORMAT: st_d.mix.format = {6'h00, wdata[`LAHP_STEREO_BIT], 1'b0}; // [R16]
                `LAHP_MIX_MAIN:   st_d.mix.main = wdata;
                `LAHP_MIX_SYNTH:  st_d.mix.synth = wdata;
                `LAHP_MIX_DISC:   st_d.mix.disc = wdata;
                `LAHP_MIX_LINE:   st_d.mix.line = wdata;
                default:          st_d.mix = st_q.mix; // [R21]
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= '{mix: '{voice: `LAHP_RST_VOICE, mic: `LAHP_RST_MIC, source: `LAHP_RST_SOURCE,
                             format: `LAHP_RST_FORMAT, main: `LAHP_RST_MAIN, synth: `LAHP_RST_SYNTH,
                             disc: `LAHP_RST_DISC, line: `LAHP_RST_LINE},
                      rd: `LAHP_RESERVED_READ};
        end else begin
            st_q <= st_d;
        end
    end

    assign regs  = st_q.mix;
    assign rdata = st_q.rd;
endmodule // lahp_mixer_bank

//--- rtl/lahp_params.svh
// constants for the legacy audio host port
// Behaviour
// (R1) only ten address bits decode; higher address bits must be zero for a hit.
// (R2) window spans sixteen I/O locations from a relocatable configured base.
// (R3) offsets 0-3 forward to synth; 0,2 read status, write select; 1,3 data.
// (R4) offset 8 reads synth status, writes select; offset 9 takes synth data.
// (R5) host writes mixer index at offset 4 before using the data port.
// (R6) offset 5 accesses the mixer register chosen by the latest index.
// (R7) writing bit 0 of offset 6 high then low resets the interface.
// (R8) offset A holds valid result data whenever offset E bit 7 is one.
// (R9) writes to offset C go to the command interpreter as command bytes.
// (R10) reading offset C gives ready in bit 7: one means can take a command.
// (R11) host polls ready before commands and data-available before reading A.
// (R12) any write to mixer index 00H restores all mixer defaults.
// (R13) index 04H voice level, left high nibble, right low, reset 99H.
// (R14) index 0AH microphone mix level in low bits, reset 01H.
// (R15) index 0CH bits 2:1 pick source: 00/10 mic, 01 disc, 11 line.
// (R16) index 0EH bit 1 selects mono (0) or stereo (1) output.
// (R17) index 22H main output level, nibble per channel, reset 99H.
// (R18) index 26H synth level, nibble per channel, reset 99H.
// (R19) index 28H disc audio level, nibble per channel, reset 01H.
// (R20) index 2EH line input level, nibble per channel, reset 01H.
// (R21) reserved mixer indices ignore writes and read a harmless value.
// (R22) shares one host interrupt and playback DMA with the native codec; the port has no interrupt or DMA logic.
// (R23) switches between compatibility and native mode without host help.
`ifndef LAHP_PARAMS_SVH
`define LAHP_PARAMS_SVH

`define LAHP_ADDR_BITS        10
`define LAHP_OFS_LSYN_SEL     4'h0
`define LAHP_OFS_LSYN_DATA    4'h1
`define LAHP_OFS_RSYN_SEL     4'h2
`define LAHP_OFS_RSYN_DATA    4'h3
`define LAHP_OFS_MIX_INDEX    4'h4
`define LAHP_OFS_MIX_DATA     4'h5
`define LAHP_OFS_SOFT_RESET   4'h6
`define LAHP_OFS_SYN_SEL      4'h8
`define LAHP_OFS_SYN_DATA     4'h9
`define LAHP_OFS_RESULT       4'hA
`define LAHP_OFS_COMMAND      4'hC
`define LAHP_OFS_AVAIL        4'hE

`define LAHP_MIX_RESET        8'h00
`define LAHP_MIX_VOICE        8'h04
`define LAHP_MIX_MIC          8'h0A
`define LAHP_MIX_SOURCE       8'h0C
`define LAHP_MIX_FORMAT       8'h0E
`define LAHP_MIX_MAIN         8'h22
`define LAHP_MIX_SYNTH        8'h26
`define LAHP_MIX_DISC         8'h28
`define LAHP_MIX_LINE         8'h2E

`define LAHP_RST_VOICE        8'h99
`define LAHP_RST_MIC          8'h01
`define LAHP_RST_SOURCE       8'h00
`define LAHP_RST_FORMAT       8'h00
`define LAHP_RST_MAIN         8'h99
`define LAHP_RST_SYNTH        8'h99
`define LAHP_RST_DISC         8'h01
`define LAHP_RST_LINE         8'h01
`define LAHP_RESERVED_READ    8'hFF

`define LAHP_MIC_MSB          2
`define LAHP_SRC_MSB          2
`define LAHP_SRC_LSB          1
`define LAHP_STEREO_BIT       1
`define LAHP_FLAG_BIT         7
`define LAHP_SOFT_RESET_BIT   0

`endif

//--- rtl/lahp_pkg.sv
// types shared by the legacy audio host port
package lahp_pkg;
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [9:0] addr;
        logic [5:0] addr_hi;
        logic [7:0] wdata;
    } lahp_io_t;

    typedef struct packed {
        logic       sel_wr;
        logic       data_wr;
        logic [1:0] port;
        logic [7:0] wdata;
    } lahp_synth_t;

    typedef struct packed {
        logic       wr;
        logic [7:0] data;
    } lahp_byte_t;

    typedef struct packed {
        logic [7:0] voice;
        logic [7:0] mic;
        logic [7:0] source;
        logic [7:0] format;
        logic [7:0] main;
        logic [7:0] synth;
        logic [7:0] disc;
        logic [7:0] line;
    } lahp_mixer_t;

    typedef enum logic [1:0] {
        LAHP_SR_IDLE,
        LAHP_SR_ARMED
    } lahp_sr_state_t;
endpackage

//--- rtl/lahp_port.sv
// legacy audio host port: window decode, synth pass-through, mixer, command interface
`timescale 1ns/1ps
`include "lahp_params.svh"
module lahp_port (
    input  wire logic                  sys_clk,
    input  wire logic                  rstn,
    input  wire logic [9:0]            compat_port_base,
    input  wire logic                  compat_enable,
    input  wire lahp_pkg::lahp_io_t    io,
    output lahp_pkg::lahp_byte_t       rdata,
    output lahp_pkg::lahp_synth_t      synth_path,
    input  wire logic [7:0]            synth_status,
    output lahp_pkg::lahp_byte_t       cmd_out,
    input  wire logic                  cmd_ready,
    input  wire lahp_pkg::lahp_byte_t  result_in,
    output logic                       result_taken,
    output lahp_pkg::lahp_mixer_t      mixer,
    output logic                       stereo_output_select,
    output logic                       interface_reset,
    output logic                       compat_mode
);
    import lahp_pkg::*;

    typedef struct packed {
        lahp_byte_t  rdata;
        lahp_synth_t syn;
        lahp_byte_t  cmd;
        logic        taken;
        logic [7:0]  index;
        logic [7:0]  result;
        logic        avail;
        logic        mode;
        logic        ireset;
    } lahp_port_st_t;

    lahp_port_st_t st_q;
    lahp_port_st_t st_d;

    logic        hit;
    logic [3:0]  ofs;
    logic        mix_wr;
    logic [7:0]  mix_rd;
    logic        sr_wr;
    logic        sr_pulse;
    lahp_mixer_t mix_regs;

    // offset inside the window, valid only with upper bits clear
    function automatic logic window_hit(input logic [9:0] a, input logic [5:0] hi, input logic [9:0] base);
        return (hi == 6'h00) && (a[9:4] == base[9:4]); // [R1] [R2]
    endfunction

    function automatic logic is_ofs(input logic [3:0] o, input logic [3:0] want);
        return o == want;
    endfunction

    assign hit    = compat_enable && window_hit(io.addr, io.addr_hi, compat_port_base);
    assign ofs    = io.addr[3:0];
    assign mix_wr = hit && io.wr && is_ofs(ofs, `LAHP_OFS_MIX_DATA); // [R6]
    assign sr_wr  = hit && io.wr && is_ofs(ofs, `LAHP_OFS_SOFT_RESET);

    lahp_mixer_bank u_mixer (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .clear   (sr_pulse),
        .wr      (mix_wr),
        .index   (st_q.index),
        .wdata   (io.wdata),
        .regs    (mix_regs),
        .rdata   (mix_rd)
    );

    lahp_soft_reset u_sreset (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .wr      (sr_wr),
        .bit0    (io.wdata[`LAHP_SOFT_RESET_BIT]),
        .pulse   (sr_pulse)
    );

    always_comb begin
        st_d            = st_q;
        st_d.rdata      = '{wr: 1'b0, data: 8'h00};
        st_d.syn        = '{sel_wr: 1'b0, data_wr: 1'b0, port: 2'b00, wdata: 8'h00};
        st_d.cmd.wr     = 1'b0;
        st_d.taken      = 1'b0;
        st_d.ireset     = 1'b0;

        // mode follows use of the window, no host sequence needed
        if (hit && (io.rd || io.wr)) begin
            st_d.mode = 1'b1; // [R23]
        end
        if (!compat_enable) begin
            st_d.mode = 1'b0; // [R22] [R23]
        end

        // latch a new result from the interpreter when the holding slot is free
        if (result_in.wr && !st_q.avail) begin
            st_d.result = result_in.data;
            st_d.avail  = 1'b1; // [R8]
        end

        if (hit && io.wr) begin
            case (ofs)
                `LAHP_OFS_LSYN_SEL, `LAHP_OFS_RSYN_SEL, `LAHP_OFS_SYN_SEL: begin
                    st_d.syn = '{sel_wr: 1'b1, data_wr: 1'b0, port: ofs[1:0], wdata: io.wdata}; // [R3] [R4]
                end
                `LAHP_OFS_LSYN_DATA, `LAHP_OFS_RSYN_DATA, `LAHP_OFS_SYN_DATA: begin
                    st_d.syn = '{sel_wr: 1'b0, data_wr: 1'b1, port: ofs[1:0], wdata: io.wdata}; // [R3] [R4]
                end
                `LAHP_OFS_MIX_INDEX: st_d.index = io.wdata; // [R5] [R6]
                `LAHP_OFS_COMMAND: begin
                    // a command sent while busy is still passed on; the interpreter owns pacing
                    st_d.cmd = '{wr: 1'b1, data: io.wdata}; // [R9] [R11]
                end
                default: st_d.syn = st_d.syn;
            endcase
        end

        if (hit && io.rd) begin
            st_d.rdata.wr = 1'b1;
            case (ofs)
                `LAHP_OFS_LSYN_SEL, `LAHP_OFS_RSYN_SEL, `LAHP_OFS_SYN_SEL:
                    st_d.rdata.data = synth_status; // [R3] [R4]
                `LAHP_OFS_MIX_DATA:
                    st_d.rdata.data = mix_rd; // [R6]
                `LAHP_OFS_RESULT: begin
                    st_d.rdata.data = st_q.result; // [R8]
                    if (st_q.avail) begin
                        st_d.avail = 1'b0;
                        st_d.taken = 1'b1;
                    end
                end
                `LAHP_OFS_COMMAND:
                    st_d.rdata.data = {cmd_ready && !st_q.cmd.wr, 7'h00}; // [R10]
                `LAHP_OFS_AVAIL:
                    st_d.rdata.data = {st_q.avail, 7'h00}; // [R8]
                default:
                    st_d.rdata.data = `LAHP_RESERVED_READ;
            endcase
        end

        if (sr_pulse) begin
            st_d.ireset = 1'b1; // [R7]
            st_d.avail  = 1'b0;
            st_d.index  = 8'h00;
            st_d.cmd    = '{wr: 1'b0, data: 8'h00};
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= '{rdata: '{wr: 1'b0, data: 8'h00},
                      syn: '{sel_wr: 1'b0, data_wr: 1'b0, port: 2'b00, wdata: 8'h00},
                      cmd: '{wr: 1'b0, data: 8'h00},
                      taken: 1'b0, index: 8'h00, result: 8'h00, avail: 1'b0,
                      mode: 1'b0, ireset: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign rdata                = st_q.rdata;
    assign synth_path           = st_q.syn;
    assign cmd_out              = st_q.cmd;
    assign result_taken         = st_q.taken;
    assign mixer                = mix_regs;
    assign stereo_output_select = mix_regs.format[`LAHP_STEREO_BIT]; // [R16]
    assign interface_reset      = st_q.ireset;
    assign compat_mode          = st_q.mode;
endmodule // lahp_port

//--- rtl/lahp_soft_reset.sv
// detects the one-then-zero soft reset sequence
`timescale 1ns/1ps
`include "lahp_params.svh"
module lahp_soft_reset (
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic wr,
    input  wire logic bit0,
    output logic      pulse
);
    import lahp_pkg::*;

    typedef struct packed {
        lahp_sr_state_t state;
        logic           pulse;
    } lahp_sr_st_t;

    lahp_sr_st_t st_q;
    lahp_sr_st_t st_d;

    always_comb begin
        st_d       = st_q;
        st_d.pulse = 1'b0;
        case (st_q.state)
            LAHP_SR_IDLE: begin
                if (wr && bit0) begin
                    st_d.state = LAHP_SR_ARMED;
                end
            end
            LAHP_SR_ARMED: begin
                if (wr && !bit0) begin // [R7]
                    st_d.state = LAHP_SR_IDLE;
                    st_d.pulse = 1'b1;
                end
            end
            default: st_d.state = LAHP_SR_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= '{state: LAHP_SR_IDLE, pulse: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign pulse = st_q.pulse;
endmodule // lahp_soft_reset
